// *** core/acc_top.sv ***
`timescale 1ns/1ps
// What this block does
// - Bit 7 turns the comparator on
// - Bit 6 picks pin or bandgap source
// - Bit 5 flag sets on selected edge
// - Writing one clears flag; zero keeps
// - Bit 4 enables interrupt from flag
// - Bit 3 reads level, zero when off
// - Bit 2 drives output onto pin
// - Modes 00,10 falling; 11 both edges
// - Keeps comparing during wait mode
// - Comparator disabled in every stop mode
// - Deep stop powers down, wakes reset
// - Light stop holds registers, no compares
// - Light stop reset exit resets; interrupt resumes
// - Debug mode does not suspend operation
// - One eight-bit status and control register, plus one-bit interrupt status and mask registers
// - Negative pin inverting; positive non-inverting
// - Output high when plus exceeds minus
module acc_top
  import acc_pkg::*;
(
  input  wire logic        pclk,           // Bus clock
  input  wire logic        presetn,        // Async reset, active low
  input  wire logic        psel,           // APB select
  input  wire logic        penable,        // APB access phase
  input  wire logic        pwrite,         // APB write
  input  wire logic [7:0]  paddr,          // APB byte address
  input  wire logic [31:0] pwdata,         // APB write data
  output logic      [31:0] prdata,         // APB read data
  output logic             pready,         // APB ready
  output logic             pslverr,        // APB error
  input  wire logic        wait_mode,      // Processor in wait
  input  wire logic        stop_light,     // Lightest stop mode active
  input  wire logic        stop_deep,      // Deepest stop mode active
  input  wire logic        debug_active,   // Background debug active
  input  wire logic        cmp_raw,        // Analog comparator decision, async
  output logic             cmp_power_on,   // Comparator powered
  output logic             ref_sel_bandgap,// 1 bandgap, 0 positive pin
  output logic             pos_pin_connect,// Positive pin on plus input
  output logic             neg_pin_connect,// Negative pin on minus input
  output logic             digital_out,    // Output pin data
  output logic             digital_out_oe_n,// Output pin enable, low drives
  output logic             cmp_irq,        // Compare-event interrupt request
  output logic             irq             // Masked status interrupt
);

  logic [7:0] ctrl_r;
  logic       flag_r;
  logic       sync1_r;
  logic       sync2_r;
  logic       level_r;
  logic       level_nxt;
  logic [7:0] ctrl_nxt;
  logic [1:0] warm_r;
  logic       primed_r;
  logic       dout_r;
  logic       stat_r;
  logic       mask_r;
  logic       deep_was_r;
  acc_pwr_t   pwr_r;
  acc_pwr_t   pwr_nxt;

  logic module_enable;
  logic edge_rise;
  logic edge_fall;
  logic event_hit;
  logic active;
  logic wr_en;
  logic rd_en;
  logic addr_ok;
  logic flag_clr;
  logic stat_clr;
  logic soft_reset;
  logic [1:0] edge_select_field;
  logic       sample_ok;
  logic       hit_ctrl;
  logic       hit_stat;
  logic       hit_mask;
  logic       ctrl_wr;
  logic       mask_wr;
  logic [31:0] rd_mux;

  assign module_enable     = ctrl_r[ACC_BIT_ENABLE];
  assign edge_select_field = ctrl_r[ACC_EDGE_HI:ACC_EDGE_LO];

  // Every field must fit the eight-bit register and no two may overlap.
  localparam int FIELD_POS [8] = '{ACC_BIT_ENABLE, ACC_BIT_REFSEL, ACC_BIT_FLAG, ACC_BIT_IE,
                                   ACC_BIT_LEVEL, ACC_BIT_OPE, ACC_EDGE_HI, ACC_EDGE_LO};
  for (genvar i = 0; i < 8; i++) begin : g_field_chk
    if (FIELD_POS[i] < 0 || FIELD_POS[i] > 7) begin : g_range
      $error("control field outside the eight-bit register");
    end
    for (genvar j = i + 1; j < 8; j++) begin : g_pair
      if (FIELD_POS[i] == FIELD_POS[j]) begin : g_clash
        $error("two control fields share one bit");
      end
    end
  end

  if (ACC_EDGE_HI != ACC_EDGE_LO + 1) begin : g_mode_chk
    $error("edge select field must be two adjacent bits");
  end

  if (ACC_IRQ_W != 1 || ACC_IRQ_EVENT != 0) begin : g_irq_chk
    $error("interrupt status layout must be a single bit zero");
  end

  // Power state follows the system mode inputs; deep stop wins.
  // Wait and debug need no decode here: neither one pauses the block.
  always_comb begin
    case ({stop_deep, stop_light})
      2'b00:   pwr_nxt = ACC_PWR_RUN;
      2'b01:   pwr_nxt = ACC_PWR_LIGHT;
      2'b10:   pwr_nxt = ACC_PWR_DEEP;
      2'b11:   pwr_nxt = ACC_PWR_DEEP;
      default: pwr_nxt = ACC_PWR_RUN;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwr_r <= ACC_PWR_RUN;
    end else begin
      pwr_r <= pwr_nxt;
    end
  end

  // Wait and debug leave the comparator running; only stop halts it.
  always_comb begin
    case (pwr_r)
      ACC_PWR_RUN:   active = module_enable;
      ACC_PWR_LIGHT: active = 1'b0;
      ACC_PWR_DEEP:  active = 1'b0;
      default:       active = 1'b0;
    endcase
  end

  // Leaving deep stop restores the reset state, as if powered down.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      deep_was_r <= 1'b0;
    end else begin
      deep_was_r <= (pwr_r == ACC_PWR_DEEP);
    end
  end

  assign soft_reset = deep_was_r && (pwr_r != ACC_PWR_DEEP);

  // Two-flop synchroniser; sync1_r feeds only sync2_r.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
    end else begin
      sync1_r <= cmp_raw;
      sync2_r <= sync1_r;
    end
  end

  // A powered-down stage leaves junk in the synchroniser; after every
  // power-up, wait until both flops hold fresh decisions before sampling.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      warm_r <= 2'h0;
    end else if (!active) begin
      warm_r <= 2'h0;
    end else if (warm_r != 2'h2) begin
      warm_r <= warm_r + 2'h1;
    end
  end

  assign sample_ok = active && (warm_r == 2'h2);

  // Sampled level is frozen outside run so light stop resumes cleanly.
  always_comb begin
    level_nxt = level_r;
    if (soft_reset || !module_enable) begin
      level_nxt = 1'b0;
    end else if (sample_ok) begin
      level_nxt = sync2_r;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level_r <= 1'b0;
    end else begin
      level_r <= level_nxt;
    end
  end

  // The first sample after enable only seeds the history, so a comparator
  // that is already high does not look like a rising edge.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      primed_r <= 1'b0;
    end else if (soft_reset || !module_enable) begin
      primed_r <= 1'b0;
    end else if (sample_ok) begin
      primed_r <= 1'b1;
    end
  end

  // Fresh sample against the held one: one pulse per change, never repeated.
  assign edge_rise = sample_ok && primed_r && sync2_r && !level_r;
  assign edge_fall = sample_ok && primed_r && !sync2_r && level_r;

  always_comb begin
    case (edge_select_field)
      ACC_MODE_FALL0: event_hit = edge_fall;
      ACC_MODE_RISE:  event_hit = edge_rise;
      ACC_MODE_FALL2: event_hit = edge_fall;
      ACC_MODE_BOTH:  event_hit = edge_rise || edge_fall;
      default:        event_hit = 1'b0;
    endcase
  end

  // APB: zero wait states; unmapped addresses answer with an error.
  // No wait states keeps the master simple; every access ends in one cycle.
  assign pready   = 1'b1;
  assign hit_ctrl = (paddr == ACC_OFF_CTRL);
  assign hit_stat = (paddr == ACC_OFF_IRQ_STAT);
  assign hit_mask = (paddr == ACC_OFF_IRQ_MASK);
  assign addr_ok  = hit_ctrl || hit_stat || hit_mask;
  assign pslverr  = psel && penable && !addr_ok;
  assign wr_en    = psel && penable && pwrite;
  assign rd_en    = psel && !penable && !pwrite;
  assign ctrl_wr  = wr_en && hit_ctrl;
  assign mask_wr  = wr_en && hit_mask;

  // Write one to clear; a zero leaves the bit alone.
  assign flag_clr = ctrl_wr && pwdata[ACC_BIT_FLAG];
  assign stat_clr = wr_en && hit_stat && pwdata[ACC_IRQ_EVENT];

  // Control bits; the flag and level positions hold no state here.
  always_comb begin
    ctrl_nxt = ctrl_r;
    if (soft_reset) begin
      ctrl_nxt = ACC_CTRL_RST;
    end else if (ctrl_wr) begin
      ctrl_nxt = pwdata[7:0] & 8'hD7;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= ACC_CTRL_RST;
    end else begin
      ctrl_r <= ctrl_nxt;
    end
  end

  // Pin data comes from a flop fed by the next register values, so it
  // lines up with the pin enable without a combinational path to the pin.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dout_r <= 1'b0;
    end else begin
      dout_r <= ctrl_nxt[ACC_BIT_OPE] && level_nxt;
    end
  end

  // A new event in the clear cycle wins over the clear.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_r <= 1'b0;
    end else if (soft_reset) begin
      flag_r <= 1'b0;
    end else if (event_hit) begin
      flag_r <= 1'b1;
    end else if (flag_clr) begin
      flag_r <= 1'b0;
    end
  end

  // Status mirrors the flag for the masked line; set beats clear here too.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_r <= 1'b0;
    end else if (soft_reset) begin
      stat_r <= 1'b0;
    end else if (event_hit) begin
      stat_r <= 1'b1;
    end else if (stat_clr) begin
      stat_r <= 1'b0;
    end
  end

  // The mask only gates the line; the status bit records events regardless.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_r <= ACC_MASK_RST;
    end else if (soft_reset) begin
      mask_r <= ACC_MASK_RST;
    end else if (mask_wr) begin
      mask_r <= pwdata[ACC_IRQ_EVENT];
    end
  end

  // Read data is registered in the setup cycle, stable in access.
  // Unmapped offsets read as zero.
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (paddr)
      ACC_OFF_CTRL: begin
        rd_mux[7:0]           = ctrl_r;
        rd_mux[ACC_BIT_FLAG]  = flag_r;
        rd_mux[ACC_BIT_LEVEL] = level_r;
      end
      ACC_OFF_IRQ_STAT: rd_mux[ACC_IRQ_EVENT] = stat_r;
      ACC_OFF_IRQ_MASK: rd_mux[ACC_IRQ_EVENT] = mask_r;
      default:          rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_en) begin
      prdata <= rd_mux;
    end
  end

  // Pin routing follows the source select; the minus pin is always on.
  assign cmp_power_on     = active;
  assign ref_sel_bandgap  = ctrl_r[ACC_BIT_REFSEL];
  assign pos_pin_connect  = !ctrl_r[ACC_BIT_REFSEL];
  assign neg_pin_connect  = 1'b1;
  assign digital_out      = dout_r;
  assign digital_out_oe_n = !ctrl_r[ACC_BIT_OPE];
  // Both requests are levels that stand until software clears the cause.
  assign cmp_irq          = ctrl_r[ACC_BIT_IE] && flag_r;
  assign irq              = stat_r && mask_r;

endmodule // acc_top

// *** shared/acc_pkg.sv ***
package acc_pkg;
  // APB byte addresses of the block's registers
  localparam logic [7:0] ACC_OFF_CTRL     = 8'h00;
  localparam logic [7:0] ACC_OFF_IRQ_STAT = 8'h04;
  localparam logic [7:0] ACC_OFF_IRQ_MASK = 8'h08;
  // Control register field positions
  localparam int ACC_BIT_ENABLE  = 7;
  localparam int ACC_BIT_REFSEL  = 6;
  localparam int ACC_BIT_FLAG    = 5;
  localparam int ACC_BIT_IE      = 4;
  localparam int ACC_BIT_LEVEL   = 3;
  localparam int ACC_BIT_OPE     = 2;
  localparam int ACC_EDGE_HI     = 1;
  localparam int ACC_EDGE_LO     = 0;
  // Interrupt status / mask layout
  localparam int ACC_IRQ_EVENT   = 0;
  localparam int ACC_IRQ_W       = 1;
  // Reset values
  localparam logic [7:0] ACC_CTRL_RST = 8'h00;
  localparam logic [0:0] ACC_MASK_RST = 1'h0;
  // Edge select encodings
  localparam logic [1:0] ACC_MODE_FALL0 = 2'h0;
  localparam logic [1:0] ACC_MODE_RISE  = 2'h1;
  localparam logic [1:0] ACC_MODE_FALL2 = 2'h2;
  localparam logic [1:0] ACC_MODE_BOTH  = 2'h3;
  // Power state encodings
  typedef enum logic [2:0] {
    ACC_PWR_RUN   = 3'h1,
    ACC_PWR_LIGHT = 3'h2,
    ACC_PWR_DEEP  = 3'h4
  } acc_pwr_t;
endpackage

// *** bench/acc_chk.sv ***
`timescale 1ns/1ps
module acc_chk
  import acc_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pslverr,
  input wire logic        stop_light,
  input wire logic        stop_deep,
  input wire logic        cmp_power_on,
  input wire logic        ref_sel_bandgap,
  input wire logic        pos_pin_connect,
  input wire logic        neg_pin_connect,
  input wire logic        digital_out,
  input wire logic        digital_out_oe_n,
  input wire logic        cmp_irq,
  input wire logic        irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic wr_c;
  assign wr_c = psel && penable && pwrite && paddr == ACC_OFF_CTRL;
  pin_route_a: assert property (neg_pin_connect && pos_pin_connect != ref_sel_bandgap)
    else $error("input routing wrong");
  ref_write_a: assert property (wr_c |=> ref_sel_bandgap == $past(pwdata[ACC_BIT_REFSEL]))
    else $error("source select not taken");
  pin_write_a: assert property (wr_c |=> digital_out_oe_n == !$past(pwdata[ACC_BIT_OPE]))
    else $error("pin enable not taken");
  pin_off_a: assert property (digital_out_oe_n |-> !digital_out)
    else $error("pin driven while off");
  off_write_a: assert property (wr_c && !pwdata[ACC_BIT_ENABLE] |=> !cmp_power_on)
    else $error("powered while disabled");
  stop_off_a: assert property (stop_light || stop_deep |=> !cmp_power_on)
    else $error("powered in stop");
  ie_off_a: assert property (wr_c && !pwdata[ACC_BIT_IE] |=> !cmp_irq)
    else $error("request without enable");
  deep_exit_a: assert property ($fell(stop_deep) |-> ##[0:2] !ref_sel_bandgap && digital_out_oe_n)
    else $error("no reset after deep stop");
  light_hold_a: assert property (stop_light && !stop_deep && !wr_c |=> $stable(digital_out_oe_n))
    else $error("state lost in light stop");
  bad_addr_a: assert property (psel && penable && paddr > ACC_OFF_IRQ_MASK |-> pslverr)
    else $error("unmapped access accepted");
  cover property (cmp_irq);
  cover property (irq);
  cover property ($fell(stop_deep));
endmodule // acc_chk
bind acc_top acc_chk u_chk (.*);

// *** bench/acc_cmp_model.sv ***
`timescale 1ns/1ps
module acc_cmp_model #(parameter logic [7:0] BANDGAP = 8'h80) (
  input  wire logic [7:0] pos_v,           // Positive pin voltage
  input  wire logic [7:0] neg_v,           // Negative pin voltage
  input  wire logic       ref_sel_bandgap, // Plus from bandgap
  input  wire logic       pos_pin_connect, // Plus from pin
  input  wire logic       neg_pin_connect, // Minus from pin
  input  wire logic       cmp_power_on,    // Stage powered
  output logic            cmp_raw          // Decision
);
  logic [7:0] plus_v;
  logic       d;
  assign plus_v = ref_sel_bandgap ? BANDGAP : (pos_pin_connect ? pos_v : 8'h00);
  assign d = neg_pin_connect && plus_v > neg_v;
  // Unpowered stage gives the wrong answer so a missing power gate shows
  assign cmp_raw = cmp_power_on ? d : !d;
endmodule // acc_cmp_model

// *** bench/acc_top_bench.sv ***
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin num_errors++; \
  $display("MISMATCH %0t got %h exp %h", $time, g, e); end end
module acc_top_bench;
  import acc_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, wait_mode, stop_light, stop_deep, debug_active;
  logic [7:0]  paddr, pos_v, neg_v;
  logic [31:0] pwdata, prdata, q;
  logic pready, pslverr, e, cmp_raw, cmp_power_on, ref_sel_bandgap, pos_pin_connect;
  logic neg_pin_connect, digital_out, digital_out_oe_n, cmp_irq, irq;
  int   num_errors = 0, compares = 0;
  acc_top u_dut (.*);
  acc_cmp_model u_cmp (.*);
  initial begin
    pclk = 0;
    forever #12.5 pclk = ~pclk;
  end
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1 && ++n < 50);
    if (pready !== 1'b1) num_errors++;
    q = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask
  task t_reset;
    apb(0, ACC_OFF_CTRL, 0);
    `CHK(q, {24'h0, ACC_CTRL_RST})
    `CHK(cmp_power_on, 1'b0)
    apb(0, 8'h0C, 0);
    `CHK({e, q}, 33'h100000000)
  endtask
  task t_fields;
    apb(1, ACC_OFF_CTRL, 32'h44);
    apb(0, ACC_OFF_CTRL, 0);
    `CHK(q[7:0], 8'h44)
    `CHK({ref_sel_bandgap, pos_pin_connect, neg_pin_connect}, 3'b101)
    `CHK({digital_out_oe_n, digital_out, cmp_power_on}, 3'b000)
    apb(1, ACC_OFF_CTRL, 32'hC0);
    neg_v <= 8'h40;
    repeat (6) @(posedge pclk);
    apb(0, ACC_OFF_CTRL, 0);
    `CHK(q[3], 1'b1)
  endtask
  task t_modes;
    logic [7:0] c;
    neg_v <= 8'h80;
    for (int m = 0; m < 4; m++) begin
      c = 8'h94 | m[7:0];
      pos_v <= 8'h10;
      apb(1, ACC_OFF_CTRL, {24'h0, c | 8'h20});
      repeat (6) @(posedge pclk);
      apb(1, ACC_OFF_CTRL, {24'h0, c | 8'h20});
      pos_v <= 8'hF0;
      repeat (6) @(posedge pclk);
      apb(0, ACC_OFF_CTRL, 0);
      `CHK(q[7:0], c | 8'h08 | (m[0] ? 8'h20 : 8'h00))
      `CHK({cmp_irq, digital_out}, {m[0], 1'b1})
      apb(1, ACC_OFF_CTRL, {24'h0, c});
      apb(0, ACC_OFF_CTRL, 0);
      `CHK(q[5], m[0])
      apb(1, ACC_OFF_CTRL, {24'h0, c | 8'h20});
      apb(0, ACC_OFF_CTRL, 0);
      `CHK(q[7:0], c | 8'h08)
      pos_v <= 8'h10;
      repeat (6) @(posedge pclk);
      apb(0, ACC_OFF_CTRL, 0);
      `CHK(q[7:0], c | (m == 1 ? 8'h00 : 8'h20))
    end
  endtask
  task t_irq;
    apb(1, ACC_OFF_IRQ_MASK, 1);
    `CHK(irq, 1'b1)
    apb(1, ACC_OFF_IRQ_MASK, 0);
    `CHK(irq, 1'b0)
    apb(1, ACC_OFF_IRQ_MASK, 1);
    apb(1, ACC_OFF_IRQ_STAT, 1);
    apb(0, ACC_OFF_IRQ_STAT, 0);
    `CHK({irq, q}, 33'h0)
  endtask
  task t_stop;
    apb(1, ACC_OFF_CTRL, 32'hB3);
    stop_light <= 1;
    repeat (2) @(posedge pclk);
    `CHK(cmp_power_on, 1'b0)
    // Pulse returns to its old level so no edge is left pending on resume
    pos_v <= 8'hF0;
    repeat (4) @(posedge pclk);
    pos_v <= 8'h10;
    repeat (4) @(posedge pclk);
    stop_light <= 0;
    repeat (6) @(posedge pclk);
    apb(0, ACC_OFF_CTRL, 0);
    `CHK(q[7:0], 8'h93)
    wait_mode <= 1;
    debug_active <= 1;
    pos_v <= 8'hF0;
    repeat (6) @(posedge pclk);
    `CHK(cmp_irq, 1'b1)
    stop_deep <= 1;
    repeat (3) @(posedge pclk);
    stop_deep <= 0;
    repeat (3) @(posedge pclk);
    apb(0, ACC_OFF_CTRL, 0);
    `CHK(q[7:0], ACC_CTRL_RST)
  endtask
  task complete_run;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    {presetn, psel, penable, pwrite, wait_mode, stop_light, stop_deep, debug_active} = 8'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    pos_v = 8'h10;
    neg_v = 8'h80;
    repeat (6) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    t_reset;
    t_fields;
    t_modes;
    t_irq;
    t_stop;
    complete_run;
  end
  initial begin
    #200000;
    num_errors++;
    complete_run;
  end
endmodule // acc_top_bench
